// ==== shared/cfsi_pkg.sv ====
package cfsi_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int PTR_W = 6;
  localparam int BUF_IDX_W = 5;
  localparam int ERR_W = 6;

  localparam logic [ADDR_W-1:0] ADDR_FIFO_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAG = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_ENABLE = 4'h2;

  localparam int FIFO_WPTR_LSB = 8;
  localparam int FIFO_RPTR_LSB = 0;

  localparam int ERR_LSB = 8;
  localparam int TX_BUSOFF_BIT = 13;
  localparam int TX_PASSIVE_BIT = 12;
  localparam int RX_PASSIVE_BIT = 11;
  localparam int TX_WARNING_BIT = 10;
  localparam int RX_WARNING_BIT = 9;
  localparam int ANY_WARNING_BIT = 8;

  localparam int INVALID_MSG_BIT = 7;
  localparam int WAKEUP_BIT = 6;
  localparam int ERROR_EVENT_BIT = 5;
  localparam int FIFO_ALMOST_FULL_BIT = 3;
  localparam int RX_OVERFLOW_BIT = 2;
  localparam int RX_BUFFER_BIT = 1;
  localparam int TX_BUFFER_BIT = 0;

  localparam logic [DATA_W-1:0] EVENT_MASK = 16'h00ef;
  localparam logic [DATA_W-1:0] FIFO_STATUS_MASK = 16'h3f3f;
  localparam logic [DATA_W-1:0] FLAG_STATUS_MASK = 16'h3fef;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam logic [ERR_W-1:0] ERR_RESET = 6'h00;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
  } cfsi_bus_s;

  typedef struct packed {
    logic invalid_msg;
    logic wakeup;
    logic fifo_almost_full;
    logic rx_overflow;
    logic rx_buffer;
    logic tx_buffer;
  } cfsi_event_s;

  typedef struct packed {
    logic tx_busoff;
    logic tx_passive;
    logic rx_passive;
    logic tx_warning;
    logic rx_warning;
  } cfsi_err_s;

  typedef struct packed {
    logic                  wr_load;
    logic [BUF_IDX_W-1:0]  wr_idx;
    logic                  rd_load;
    logic [BUF_IDX_W-1:0]  rd_idx;
  } cfsi_ptr_s;

  typedef struct packed {
    logic [DATA_W-1:0]     flags;
    logic [DATA_W-1:0]     enable;
    logic [PTR_W-1:0]      wptr;
    logic [PTR_W-1:0]      rptr;
    logic [ERR_W-1:0]      err;
    logic [DATA_W-1:0]     rdata;
  } cfsi_state_s;

endpackage

// ==== logic/cfsi_flags.sv ====
// Operation
// - FIFO write pointer readable, buffers 0 to 31.
// - FIFO next read pointer readable, same encoding.
// - Unused register bits read zero, ignore writes.
// - Bit 13 shows transmitter bus-off state.
// - Bit 12 shows transmitter error-passive state.
// - Bit 11 shows receiver error-passive state.
// - Bit 10 shows transmitter error-warning state.
// - Bit 9 shows receiver error-warning state.
// - Bit 8 shows either side warning.
// - Any error-state bit rising sets bit 5.
// - Invalid message event sets bit 7.
// - Bus wake-up activity sets bit 6.
// - FIFO almost full sets bit 3.
// - Receive buffer overflow sets bit 2.
// - Receive buffer event sets bit 1.
// - Transmit buffer event sets bit 0.
// - Software clears flags by writing zero only.
// - Each flag has a matching enable bit.
//
// The register offsets and the plain strobed port were left to the implementer.

`timescale 1ns/100ps

module cfsi_flags
  import cfsi_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  cfsi_bus_s        BUS,
  output logic [DATA_W-1:0] RDATA,
  input  cfsi_event_s      EVENTS,
  input  cfsi_err_s        ERR_STATE,
  input  cfsi_ptr_s        FIFO_PTR,
  output logic             IRQ
);

  cfsi_state_s             s_q;
  cfsi_state_s             s_d;
  logic [DATA_W-1:0]       ev_vec;
  logic [ERR_W-1:0]        err_now;
  logic [DATA_W-1:0]       fifo_rd;
  logic [DATA_W-1:0]       flag_rd;
  logic                    wr_flag;
  logic                    wr_enable;

  assign wr_flag = BUS.wr && (BUS.addr == ADDR_EVENT_FLAG);
  assign wr_enable = BUS.wr && (BUS.addr == ADDR_EVENT_ENABLE);

  // Read images are built from held state so a read never sees a half-updated word.
  always_comb
  begin
    fifo_rd = REG_RESET;
    fifo_rd[FIFO_WPTR_LSB +: PTR_W] = s_q.wptr;
    fifo_rd[FIFO_RPTR_LSB +: PTR_W] = s_q.rptr;
    flag_rd = s_q.flags & EVENT_MASK;
    flag_rd[ERR_LSB +: ERR_W] = s_q.err;
  end

  always_comb
  begin
    s_d = s_q;

    err_now = {ERR_STATE.tx_busoff,
               ERR_STATE.tx_passive,
               ERR_STATE.rx_passive,
               ERR_STATE.tx_warning,
               ERR_STATE.rx_warning,
               ERR_STATE.tx_warning | ERR_STATE.rx_warning};
    s_d.err = err_now;

    ev_vec = REG_RESET;
    ev_vec[INVALID_MSG_BIT] = EVENTS.invalid_msg;
    ev_vec[WAKEUP_BIT] = EVENTS.wakeup;
    // Only an entry into a state counts, so a long bus-off does not re-raise the flag.
    ev_vec[ERROR_EVENT_BIT] = |(err_now & ~s_q.err);
    ev_vec[FIFO_ALMOST_FULL_BIT] = EVENTS.fifo_almost_full;
    ev_vec[RX_OVERFLOW_BIT] = EVENTS.rx_overflow;
    ev_vec[RX_BUFFER_BIT] = EVENTS.rx_buffer;
    ev_vec[TX_BUFFER_BIT] = EVENTS.tx_buffer;

    // The pointer inputs are five bits wide, so bit 5 can never leave zero.
    if (FIFO_PTR.wr_load)
    begin
      s_d.wptr = {1'b0, FIFO_PTR.wr_idx};
    end
    if (FIFO_PTR.rd_load)
    begin
      s_d.rptr = {1'b0, FIFO_PTR.rd_idx};
    end

    if (wr_flag)
    begin
      s_d.flags = s_q.flags & BUS.wdata;
    end
    // Setting comes after clearing, so an event in the clearing cycle survives.
    s_d.flags = (s_d.flags | ev_vec) & EVENT_MASK;

    if (wr_enable)
    begin
      s_d.enable = BUS.wdata & EVENT_MASK;
    end

    s_d.rdata = REG_RESET;
    if (BUS.rd)
    begin
      case (BUS.addr)
        ADDR_FIFO_STATUS:  s_d.rdata = fifo_rd;
        ADDR_EVENT_FLAG:   s_d.rdata = flag_rd;
        ADDR_EVENT_ENABLE: s_d.rdata = s_q.enable;
        default:           s_d.rdata = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      s_q.flags <= REG_RESET;
      s_q.enable <= REG_RESET;
      s_q.wptr <= PTR_RESET;
      s_q.rptr <= PTR_RESET;
      s_q.err <= ERR_RESET;
      s_q.rdata <= REG_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  // A combined level from the flag and enable registers; it drops the cycle after a clear or a disable.
  assign IRQ = |(s_q.flags & s_q.enable);

  AST_FIFO_READ:
  assert property (@(posedge MCLK) disable iff (RST)
    (BUS.rd && BUS.addr == ADDR_FIFO_STATUS)
    |=> RDATA == {2'b00, $past(s_q.wptr), 2'b00, $past(s_q.rptr)})
  else $error("FIFO status read returned wrong pointers");

  AST_WPTR_LOAD:
  assert property (@(posedge MCLK) disable iff (RST)
    FIFO_PTR.wr_load |=> s_q.wptr == {1'b0, $past(FIFO_PTR.wr_idx)})
  else $error("Write pointer did not take the loaded index");

  AST_RPTR_HOLD:
  assert property (@(posedge MCLK) disable iff (RST)
    !FIFO_PTR.rd_load |=> s_q.rptr == $past(s_q.rptr))
  else $error("Next read pointer moved without a load");

  AST_RPTR_LOAD:
  assert property (@(posedge MCLK) disable iff (RST)
    FIFO_PTR.rd_load |=> s_q.rptr == {1'b0, $past(FIFO_PTR.rd_idx)})
  else $error("Next read pointer did not take the loaded index");

  AST_UNUSED_ZERO:
  assert property (@(posedge MCLK) disable iff (RST)
    BUS.rd |=> ($past(BUS.addr) != ADDR_EVENT_FLAG || (RDATA & ~FLAG_STATUS_MASK) == REG_RESET)
      && ($past(BUS.addr) != ADDR_FIFO_STATUS || (RDATA & ~FIFO_STATUS_MASK) == REG_RESET)
      && ($past(BUS.addr) != ADDR_EVENT_ENABLE || (RDATA & ~EVENT_MASK) == REG_RESET))
  else $error("Unused bit read back as one");

  AST_ENABLE_UNUSED:
  assert property (@(posedge MCLK) disable iff (RST)
    wr_enable |=> (s_q.enable & ~EVENT_MASK) == REG_RESET)
  else $error("Enable register stored an unused bit");

  AST_BUSOFF:
  assert property (@(posedge MCLK) disable iff (RST)
    ##1 flag_rd[TX_BUSOFF_BIT] == $past(ERR_STATE.tx_busoff))
  else $error("Bus-off status does not follow the transmitter");

  AST_TX_PASSIVE:
  assert property (@(posedge MCLK) disable iff (RST)
    $rose(ERR_STATE.tx_passive) |=> flag_rd[TX_PASSIVE_BIT])
  else $error("Transmitter passive status missing");

  AST_RX_PASSIVE:
  assert property (@(posedge MCLK) disable iff (RST)
    ##1 flag_rd[RX_PASSIVE_BIT] == $past(ERR_STATE.rx_passive))
  else $error("Receiver passive status does not follow the receiver");

  AST_TX_WARNING:
  assert property (@(posedge MCLK) disable iff (RST)
    $fell(ERR_STATE.tx_warning) |=> !flag_rd[TX_WARNING_BIT])
  else $error("Transmitter warning status stuck high");

  AST_RX_WARNING:
  assert property (@(posedge MCLK) disable iff (RST)
    ##1 flag_rd[RX_WARNING_BIT] == $past(ERR_STATE.rx_warning))
  else $error("Receiver warning status does not follow the receiver");

  AST_ANY_WARNING:
  assert property (@(posedge MCLK) disable iff (RST)
    flag_rd[ANY_WARNING_BIT] == (flag_rd[TX_WARNING_BIT] | flag_rd[RX_WARNING_BIT]))
  else $error("Combined warning differs from its two sources");

  AST_ERROR_EVENT:
  assert property (@(posedge MCLK) disable iff (RST)
    (|(err_now & ~s_q.err)) |=> s_q.flags[ERROR_EVENT_BIT])
  else $error("Entry into an error state did not set the error flag");

  AST_ERROR_QUIET:
  assert property (@(posedge MCLK) disable iff (RST)
    (!s_q.flags[ERROR_EVENT_BIT] && err_now == s_q.err)
    |=> !s_q.flags[ERROR_EVENT_BIT])
  else $error("Error flag set without a state change");

  AST_INVALID_SET:
  assert property (@(posedge MCLK) disable iff (RST)
    EVENTS.invalid_msg |=> s_q.flags[INVALID_MSG_BIT])
  else $error("Invalid message event lost");

  AST_WAKEUP_SET:
  assert property (@(posedge MCLK) disable iff (RST)
    EVENTS.wakeup |=> s_q.flags[WAKEUP_BIT])
  else $error("Wake-up event lost");

  AST_ALMOST_FULL_SET:
  assert property (@(posedge MCLK) disable iff (RST)
    EVENTS.fifo_almost_full |=> s_q.flags[FIFO_ALMOST_FULL_BIT])
  else $error("FIFO almost full event lost");

  AST_OVERFLOW_SET:
  assert property (@(posedge MCLK) disable iff (RST)
    EVENTS.rx_overflow |=> s_q.flags[RX_OVERFLOW_BIT])
  else $error("Receive overflow event lost");

  AST_RX_BUFFER_SET:
  assert property (@(posedge MCLK) disable iff (RST)
    EVENTS.rx_buffer |=> s_q.flags[RX_BUFFER_BIT])
  else $error("Receive buffer event lost");

  AST_TX_BUFFER_SET:
  assert property (@(posedge MCLK) disable iff (RST)
    EVENTS.tx_buffer |=> s_q.flags[TX_BUFFER_BIT])
  else $error("Transmit buffer event lost");

  AST_WRITE_ONE_NO_SET:
  assert property (@(posedge MCLK) disable iff (RST)
    (wr_flag && !EVENTS.tx_buffer && !s_q.flags[TX_BUFFER_BIT])
    |=> !s_q.flags[TX_BUFFER_BIT])
  else $error("Software write set a flag");

  AST_WRITE_ZERO_CLEARS:
  assert property (@(posedge MCLK) disable iff (RST)
    (wr_flag && !BUS.wdata[RX_BUFFER_BIT] && !EVENTS.rx_buffer)
    |=> !s_q.flags[RX_BUFFER_BIT])
  else $error("Writing zero did not clear the flag");

  AST_SET_BEATS_CLEAR:
  assert property (@(posedge MCLK) disable iff (RST)
    (wr_flag && BUS.wdata == REG_RESET && EVENTS.wakeup)
    |=> s_q.flags[WAKEUP_BIT] && (!s_q.flags[TX_BUFFER_BIT] || $past(EVENTS.tx_buffer)))
  else $error("Event in the clearing cycle was lost");

  AST_FLAG_HOLD:
  assert property (@(posedge MCLK) disable iff (RST)
    (!wr_flag && s_q.flags[RX_OVERFLOW_BIT]) |=> s_q.flags[RX_OVERFLOW_BIT])
  else $error("Flag dropped without a software clear");

  AST_ENABLE_WRITE:
  assert property (@(posedge MCLK) disable iff (RST)
    wr_enable |=> s_q.enable == ($past(BUS.wdata) & EVENT_MASK))
  else $error("Enable register did not take the written value");

  AST_ENABLE_READ:
  assert property (@(posedge MCLK) disable iff (RST)
    (wr_enable ##1 (BUS.rd && BUS.addr == ADDR_EVENT_ENABLE))
    |=> RDATA == ($past(BUS.wdata, 2) & EVENT_MASK))
  else $error("Enable readback differs from the written value");

  AST_IRQ_MASKED:
  assert property (@(posedge MCLK) disable iff (RST)
    (wr_enable && BUS.wdata == REG_RESET) |=> !IRQ)
  else $error("Interrupt raised with all enables clear");

  AST_IRQ_RAISE:
  assert property (@(posedge MCLK) disable iff (RST)
    (s_q.enable[RX_OVERFLOW_BIT] && !wr_enable && EVENTS.rx_overflow) |=> IRQ)
  else $error("Enabled event did not raise the interrupt");

  AST_RESET_STATE:
  assert property (@(posedge MCLK)
    $fell(RST) |-> (s_q.flags == REG_RESET && s_q.enable == REG_RESET
      && s_q.wptr == PTR_RESET && s_q.rptr == PTR_RESET && !IRQ))
  else $error("State not cleared by reset");

endmodule // cfsi_flags

// ==== verification/tb.sv ====
`timescale 1ns/100ps

module tb;
  import cfsi_pkg::*;

  logic              mclk;
  logic              rst;
  cfsi_bus_s         bus;
  logic [DATA_W-1:0] rdata;
  cfsi_event_s       ev;
  cfsi_err_s         err;
  cfsi_ptr_s         ptr;
  logic              irq;
  int                fails;
  int                comparisons;
  int                fbit [6] = '{0, 1, 2, 3, 6, 7};
  int                ebit [5] = '{9, 10, 11, 12, 13};
  logic [DATA_W-1:0] acc;

  cfsi_flags dut_u
  (
    .MCLK      (mclk),
    .RST       (rst),
    .BUS       (bus),
    .RDATA     (rdata),
    .EVENTS    (ev),
    .ERR_STATE (err),
    .FIFO_PTR  (ptr),
    .IRQ       (irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the read edge, so they are sampled there.
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask

  // Write and read on consecutive edges, the tightest spacing the bus allows.
  task automatic wrrd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic irqchk(input logic exp);
    @(posedge mclk);
    #1;
    chk({15'h0, irq}, {15'h0, exp});
  endtask

  task automatic pulse(input int i);
    @(posedge mclk);
    ev <= cfsi_event_s'(6'(1 << i));
    @(posedge mclk);
    ev <= '0;
  endtask

  task automatic load(input logic [4:0] w, input logic [4:0] r);
    @(posedge mclk);
    ptr <= '{wr_load: 1'b1, wr_idx: w, rd_load: 1'b1, rd_idx: r};
    @(posedge mclk);
    ptr <= '0;
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge mclk);
    fails++;
    end_sim;
  end

  initial
  begin
    rst = 1'b1;
    bus = '0;
    ev = '0;
    err = '0;
    ptr = '0;
    fails = 0;
    comparisons = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rdchk(ADDR_FIFO_STATUS, 16'h0000);
    rdchk(ADDR_EVENT_FLAG, 16'h0000);
    rdchk(ADDR_EVENT_ENABLE, 16'h0000);
    load(5'h1f, 5'h00);
    rdchk(ADDR_FIFO_STATUS, 16'h1f00);
    load(5'h00, 5'h1f);
    wr(ADDR_FIFO_STATUS, 16'hffff);
    rdchk(ADDR_FIFO_STATUS, 16'h001f);
    wr(4'hf, 16'hffff);
    rdchk(4'hf, 16'h0000);
    rdchk(ADDR_EVENT_ENABLE, 16'h0000);
    acc = '0;
    for (int i = 0; i < 6; i++)
    begin
      pulse(i);
      acc[fbit[i]] = 1'b1;
      rdchk(ADDR_EVENT_FLAG, acc);
      chk({15'h0, irq}, 16'h0000);
    end
    wr(ADDR_EVENT_FLAG, 16'hffff);
    rdchk(ADDR_EVENT_FLAG, 16'h00cf);
    wr(ADDR_EVENT_FLAG, 16'hfffe);
    rdchk(ADDR_EVENT_FLAG, 16'h00ce);
    wrrd(ADDR_EVENT_ENABLE, 16'hffff, 16'h00ef);
    chk({15'h0, irq}, 16'h0001);
    wr(ADDR_EVENT_ENABLE, 16'h0000);
    irqchk(1'b0);
    wr(ADDR_EVENT_ENABLE, 16'hffff);
    wr(ADDR_EVENT_FLAG, 16'h0000);
    irqchk(1'b0);
    // An event in the very cycle of a clearing write must survive it.
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_EVENT_FLAG, wdata: 16'h0000};
    ev <= '{wakeup: 1'b1, default: 1'b0};
    @(posedge mclk);
    bus <= '0;
    ev <= '0;
    rdchk(ADDR_EVENT_FLAG, 16'h0040);
    // A neighbouring event must not leak through a single enable bit.
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_EVENT_ENABLE, 16'(1 << fbit[i]));
      pulse((i + 1) % 6);
      irqchk(1'b0);
      pulse(i);
      irqchk(1'b1);
      wr(ADDR_EVENT_FLAG, 16'h0000);
      irqchk(1'b0);
    end
    wr(ADDR_EVENT_ENABLE, 16'h0020);
    for (int j = 0; j < 5; j++)
    begin
      @(posedge mclk);
      err <= cfsi_err_s'(5'(1 << j));
      repeat (3) @(posedge mclk);
      acc = 16'h0020 | 16'(1 << ebit[j]) | ((j < 2) ? 16'h0100 : 16'h0000);
      rdchk(ADDR_EVENT_FLAG, acc);
      irqchk(1'b1);
      wr(ADDR_EVENT_FLAG, 16'h0000);
      rdchk(ADDR_EVENT_FLAG, acc & 16'hffdf);
      @(posedge mclk);
      err <= '0;
      repeat (3) @(posedge mclk);
      rdchk(ADDR_EVENT_FLAG, 16'h0000);
    end
    // Reset in mid-run must wipe flags, enables and pointers together.
    wr(ADDR_EVENT_ENABLE, 16'h00ef);
    load(5'h15, 5'h0a);
    pulse(5);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    irqchk(1'b0);
    rdchk(ADDR_FIFO_STATUS, 16'h0000);
    rdchk(ADDR_EVENT_FLAG, 16'h0000);
    rdchk(ADDR_EVENT_ENABLE, 16'h0000);
    end_sim;
  end

endmodule // tb
